// ==== src/urxeg_top.v ====
// Receive FIFO with DMA event and error interrupt gating.
// Assumes bytes arrive synchronous to core_clk_in with an error flag each.
// Pops come from the CPU or DMA side through a two-entry output buffer.
// The error flag travels with each byte through memory and buffer.
`timescale 1ns/1ps
`include "urxeg_defines.vh"
// Notes on behaviour
// - FIFO mode gives DMA event and CPU interrupt
// - Error interrupt fires when errored byte is taken in FIFO mode
// - Errored top byte at trigger: no event, error
// - Errored top byte landing in the output buffer emits one extra event
// - Extra event leaves N-1 bytes for N burst
// - Extra event pulses immediately on removal
// - No trigger events while error condition stands
module urxeg_top #(
    parameter DW = `URXEG_DATA_W,
    parameter AW = `URXEG_PTR_W,
    parameter CW = `URXEG_CNT_W
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire fifo_en_in,
    input wire [CW-1:0] trig_level_in,
    input wire rx_valid_in,
    input wire [DW-1:0] rx_data_in,
    input wire rx_err_in,
    output reg rx_ready_out,
    input wire pop_ready_in,
    output reg pop_valid_out,
    output reg [DW-1:0] pop_data_out,
    output reg pop_err_out,
    output reg rx_dma_event_out,
    output reg rx_int_out,
    output reg err_int_out,
    output reg [CW-1:0] level_out,
    output reg err_cond_out
);
    localparam DEPTH = (1 << AW);
    // Read path states, one-hot
    localparam S_IDLE = 3'b001;
    localparam S_READ = 3'b010;
    localparam S_LAND = 3'b100;

    reg [AW-1:0] wr_ptr_q, rd_ptr_q;
    reg [CW-1:0] count_q;
    reg [CW-1:0] err_cnt_q;
    reg [2:0] state_q, state_d;
    reg [DW:0] buf0_q, buf1_q;
    reg [1:0] buf_n_q;
    reg trig_seen_q;
    wire [DW:0] rd_word;

    // Counter step: one up and one down may fall in the same cycle,
    // so a set and a clear of the errored count cancel instead of racing
    function [CW-1:0] adj;
        input [CW-1:0] v;
        input up;
        input dn;
        begin
            adj = v + {{(CW-1){1'b0}}, up} - {{(CW-1){1'b0}}, dn};
        end
    endfunction

    wire full = (count_q == DEPTH[CW-1:0]);
    wire push = ce_in && rx_valid_in && !full;

    // One read in flight at a time; a read starts only if its word has a
    // slot in the output buffer, so a stalled consumer never loses data
    wire buf_room = (buf_n_q == 2'b00) ||
                    (buf_n_q == 2'b01 && state_q == S_IDLE);
    wire start_rd = (state_q == S_IDLE) && (count_q != {CW{1'b0}}) && buf_room;
    wire land = (state_q == S_LAND);
    wire out_take = pop_valid_out && pop_ready_in;

    // A landing errored word is the errored top byte leaving the FIFO
    wire land_err = land && rd_word[DW];
    wire push_err = push && rx_err_in;

    // Next-cycle counts; the flags below are registered from these so that
    // the outputs line up with level_out
    wire [CW-1:0] count_nx = adj(count_q, push, start_rd);
    wire [CW-1:0] errc_nx = adj(err_cnt_q, push_err, land_err);
    wire err_now = (errc_nx != {CW{1'b0}});
    // A trigger level of zero turns the level events off
    wire at_trig = (count_nx >= trig_level_in) && (trig_level_in != {CW{1'b0}});

    // Byte and error flag stored side by side
    urxeg_mem #(.WIDTH(DW + 1), .AW(AW)) u_mem (
        .core_clk_in(core_clk_in),
        .ce_in(ce_in),
        .wr_en_in(push),
        .wr_addr_in(wr_ptr_q),
        .wr_data_in({rx_err_in, rx_data_in}),
        .rd_addr_in(rd_ptr_q),
        .rd_data_out(rd_word)
    );

    // Read sequencing: address, memory register, then buffer
    always @* begin
        case (state_q)
            S_IDLE: state_d = start_rd ? S_READ : S_IDLE;
            S_READ: state_d = S_LAND;
            S_LAND: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // FIFO pointers, count and errored-entry count
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {CW{1'b0}};
            err_cnt_q <= {CW{1'b0}};
            state_q <= S_IDLE;
        end else if (ce_in) begin
            state_q <= state_d;
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            // The read pointer moves only as the word lands: the memory reads
            // its address every cycle, and an early move would show the next
            // slot instead. A push into the slot in flight is harmless, as the
            // memory register takes the old word no later than that push.
            if (land) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_nx;
            err_cnt_q <= errc_nx; // Errored word counted until it leaves
        end
    end

    // Two-entry output buffer; buf0 is the head shown on the port
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            buf0_q <= {(DW+1){1'b0}};
            buf1_q <= {(DW+1){1'b0}};
            buf_n_q <= 2'b00;
        end else if (ce_in) begin
            case ({land, out_take})
                2'b10: begin
                    if (buf_n_q == 2'b00) begin
                        buf0_q <= rd_word;
                    end else begin
                        buf1_q <= rd_word;
                    end
                    buf_n_q <= buf_n_q + 2'b01;
                end
                2'b01: begin
                    buf0_q <= buf1_q;
                    buf_n_q <= buf_n_q - 2'b01;
                end
                2'b11: begin
                    if (buf_n_q == 2'b01) begin
                        buf0_q <= rd_word;
                    end else begin
                        buf0_q <= buf1_q;
                        buf1_q <= rd_word;
                    end
                end
                default: begin
                    buf_n_q <= buf_n_q;
                end
            endcase
        end
    end

    // Registered outputs and event generation
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_ready_out <= 1'b0;
            pop_valid_out <= 1'b0;
            pop_data_out <= {DW{1'b0}};
            pop_err_out <= 1'b0;
            rx_dma_event_out <= 1'b0;
            rx_int_out <= 1'b0;
            err_int_out <= 1'b0;
            level_out <= {CW{1'b0}};
            err_cond_out <= 1'b0;
            trig_seen_q <= 1'b0;
        end else if (ce_in) begin
            // Ready, level and error condition come from next-cycle counts, so each output is a flop
            // Ready drops one entry early since it is registered
            rx_ready_out <= (count_nx < DEPTH[CW-1:0] - 1'b1);
            level_out <= count_nx;
            err_cond_out <= err_now;
            // Head of buffer shown after this cycle's update
            if (land && (buf_n_q == 2'b00 || (buf_n_q == 2'b01 && out_take))) begin
                pop_data_out <= rd_word[DW-1:0];
                pop_err_out <= rd_word[DW];
            end else if (out_take) begin
                pop_data_out <= buf1_q[DW-1:0];
                pop_err_out <= buf1_q[DW];
            end
            if (land) begin
                pop_valid_out <= 1'b1;
            end else if (out_take) begin
                pop_valid_out <= (buf_n_q == 2'b10);
            end
            // Error interrupt pulses as the bad byte is taken
            err_int_out <= fifo_en_in && push_err;
            // Trigger crossing edge; held while level stays at or above it
            trig_seen_q <= fifo_en_in && at_trig;
            // CPU sees a level while the count is at or above the nonzero trigger and no error stands
            rx_int_out <= fifo_en_in && at_trig && !err_now;
            // Trigger event withheld while errored bytes remain
            // Removing the errored byte emits one extra pulse
            // That pulse ignores the level, hence N-1 left for N burst
            // Pulse lasts one cycle, so it is gone before DMA re-enable
            rx_dma_event_out <= fifo_en_in &&
                ((at_trig && !trig_seen_q && !err_now) || land_err);
        end
    end
endmodule // urxeg_top

// ==== src/urxeg_defines.vh ====
// Constants for the receive FIFO event gating block.
// Assumes inclusion by bare name from the top-level design module only; the bench modules do not include it.
`ifndef URXEG_DEFINES_VH
`define URXEG_DEFINES_VH
`define URXEG_DATA_W 8
`define URXEG_FIFO_DEPTH 16
`define URXEG_PTR_W 4
`define URXEG_CNT_W 5
`define URXEG_TRIG_RST 5'h01
`define URXEG_BUF_ENTRIES 2
`endif

// ==== src/urxeg_mem.v ====
// Small memory holding received bytes with their error flag.
// Assumes one clock, synchronous write and registered read data.
`timescale 1ns/1ps
module urxeg_mem #(
    parameter WIDTH = 9,
    parameter AW = 4
) (
    input wire core_clk_in,
    input wire ce_in,
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire [AW-1:0] rd_addr_in,
    output reg [WIDTH-1:0] rd_data_out
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // Read data registered; no reset so it maps to RAM
    always @(posedge core_clk_in) begin
        if (ce_in) begin
            if (wr_en_in) begin
                mem[wr_addr_in] <= wr_data_in;
            end
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule // urxeg_mem

// ==== bench/urxeg_asserts.sv ====
// Port checker for the receive event gating block.
// Assumes a bind to urxeg_top, one clock.
`timescale 1ns/1ps
module urxeg_asserts (
    input logic core_clk_in,
    input logic rst_in,
    input logic ce_in,
    input logic fifo_en_in,
    input logic [4:0] trig_level_in,
    input logic rx_valid_in,
    input logic rx_err_in,
    input logic rx_ready_out,
    input logic rx_dma_event_out,
    input logic rx_int_out,
    input logic err_int_out,
    input logic [4:0] level_out,
    input logic err_cond_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // Errored byte taken while the FIFO has room
    sequence s_bad;
        ce_in && rx_valid_in && rx_err_in && fifo_en_in && level_out < 5'h10;
    endsequence
    chk_eint_rise: assert property (s_bad |=> err_int_out)
        else $error("no error int");
    chk_eint_cause: assert property (
        err_int_out |-> $past(rx_valid_in) && $past(rx_err_in)) else $error("stray error int");
    chk_cond_set: assert property (s_bad |=> err_cond_out)
        else $error("condition not set");
    chk_cond_cause: assert property ($rose(err_cond_out) |-> $past(rx_err_in))
        else $error("stray condition");
    chk_int_held: assert property (err_cond_out [*3] |-> !$past(rx_int_out))
        else $error("rx int under error");
    chk_mode_off: assert property ((!fifo_en_in) [*2] |-> !rx_dma_event_out && !err_int_out)
        else $error("event with mode off");
    chk_ready_full: assert property (level_out == 5'h10 |-> !rx_ready_out)
        else $error("ready when full");
    chk_rint_level: assert property (
        rx_int_out |-> level_out >= trig_level_in && !err_cond_out)
        else $error("rx int out of level");
    chk_clear_event: assert property (
        $fell(err_cond_out) && fifo_en_in |-> ##[0:2] rx_dma_event_out) else $error("no event");
endmodule // urxeg_asserts
bind urxeg_top urxeg_asserts urxeg_asserts_inst (.core_clk_in, .rst_in, .ce_in, .fifo_en_in,
    .trig_level_in,
    .rx_valid_in, .rx_err_in, .rx_ready_out, .rx_dma_event_out, .rx_int_out, .err_int_out,
    .level_out, .err_cond_out);

// ==== bench/urxeg_dma_model.sv ====
// DMA channel model: one burst of 4 per event, plus CPU pops.
// Assumes the pop handshake of urxeg_top.
`timescale 1ns/1ps
module urxeg_dma_model (
    input wire core_clk_in,
    input wire rst_in,
    input wire dma_en_in,
    input wire cpu_pop_in,
    input wire event_in,
    input wire valid_in,
    output wire ready_out
);
    logic [5:0] owed_q;
    // Disabled channel drops events, so the extra one is lost
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in)
            owed_q <= 6'h00;
        else
            owed_q <= owed_q + {event_in && dma_en_in, 2'h0} -
                (valid_in && ready_out && owed_q != 6'h00); // CPU pops owe nothing
    end
    // The CPU may pop alone when software discards data
    assign ready_out = (dma_en_in && owed_q != 6'h00) || cpu_pop_in;
endmodule // urxeg_dma_model

// ==== bench/uart_rx_fifo_dma_event_gating_test.sv ====
// Bench: clean rows, error handler path, stalled fill, reset.
// Assumes urxeg_top, its checker and the DMA model.
`timescale 1ns/1ps
module uart_rx_fifo_dma_event_gating_test;
    logic core_clk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, fifo_en_in = 1'h1, rx_err_in = 1'h0;
    logic rx_valid_in = 1'h0, dma_en = 1'h1, cpu_pop = 1'h0, rx_ready_out, pop_ready_in;
    logic pop_valid_out, pop_err_out, rx_dma_event_out, rx_int_out, err_int_out, err_cond_out;
    logic [4:0] trig_level_in = 5'h02, level_out;
    logic [7:0] rx_data_in = 8'h00, pop_data_out;
    logic [8:0] got[$];
    logic [8:0] rows[4] = '{9'h03C, 9'h000, 9'h0FF, 9'h0A5};
    int n_errors = 0, checks_done = 0, n_ev = 0, n_eint = 0;
    always #20 core_clk_in = ~core_clk_in;
    urxeg_top urxeg_top_inst (.core_clk_in, .rst_in, .ce_in, .fifo_en_in, .trig_level_in,
        .rx_valid_in, .rx_data_in, .rx_err_in, .rx_ready_out, .pop_ready_in, .pop_valid_out,
        .pop_data_out, .pop_err_out, .rx_dma_event_out, .rx_int_out, .err_int_out, .level_out,
        .err_cond_out);
    urxeg_dma_model urxeg_dma_model_inst (.core_clk_in, .rst_in, .dma_en_in(dma_en),
        .cpu_pop_in(cpu_pop), .event_in(rx_dma_event_out), .valid_in(pop_valid_out),
        .ready_out(pop_ready_in));
    // Log every taken word and count pulses
    always @(posedge core_clk_in) begin
        if (pop_valid_out === 1'h1 && pop_ready_in === 1'h1) got.push_back({pop_err_out, pop_data_out});
        n_ev += (rx_dma_event_out === 1'h1);
        n_eint += (err_int_out === 1'h1);
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Back-to-back strobes; the caller ends them with idle
    task automatic push(input logic [8:0] w);
        @(negedge core_clk_in);
        rx_valid_in = 1'h1;
        {rx_err_in, rx_data_in} = w;
    endtask
    task automatic idle(input int n);
        @(negedge core_clk_in);
        rx_valid_in = 1'h0;
        repeat (n) @(negedge core_clk_in);
    endtask
    // Bounded wait for taken words; running out ends the run
    task automatic wait_got(input int n);
        for (int k = 0; k < 200 && got.size() < n; k++) @(negedge core_clk_in);
        if (got.size() < n) begin
            n_errors++;
            $display("MISMATCH %0t timeout", $time);
            wrap_up();
        end
    endtask
    initial begin
        repeat (6) @(negedge core_clk_in);
        rst_in = 1'h0;
        foreach (rows[i]) push(rows[i]);
        idle(2);
        wait_got(4);
        foreach (rows[i]) check(got[i], rows[i]);
        // Handler path: channel off while the errored byte leaves
        dma_en = 1'h0;
        n_ev = 0;
        // Level reaches the trigger while the errored byte is on top
        push(9'h1EE);
        push(9'h011);
        push(9'h022);
        idle(8);
        check(9'(n_ev), 9'h001);
        check(9'(n_eint), 9'h001);
        check({8'h00, err_cond_out}, 9'h000);
        cpu_pop = 1'h1;
        wait_got(7);
        cpu_pop = 1'h0;
        check(got[4], 9'h1EE);
        check(got[5], 9'h011);
        check(got[6], 9'h022);
        dma_en = 1'h1;
        foreach (rows[i]) push(rows[i]);
        idle(2);
        wait_got(11);
        foreach (rows[i]) check(got[7 + i], rows[i]);
        // Stalled receiver, clean bytes: one trigger event; low enable freezes all
        dma_en = 1'h0;
        n_ev = 0;
        foreach (rows[i]) push(rows[i]);
        push(9'h011);
        idle(8);
        check({3'h0, rx_int_out, level_out}, 9'h023);
        check(9'(n_ev), 9'h001);
        ce_in = 1'h0;
        push(9'h1EE);
        idle(3);
        ce_in = 1'h1;
        check({3'h0, rx_int_out, level_out}, 9'h023);
        check({8'h00, err_cond_out}, 9'h000);
        cpu_pop = 1'h1;
        wait_got(16);
        cpu_pop = 1'h0;
        foreach (rows[i]) check(got[11 + i], rows[i]);
        check(got[15], 9'h011);
        // Stalled far side, mode off: fill past full, then reset mid-run
        dma_en = 1'h0;
        fifo_en_in = 1'h0;
        n_ev = 0;
        for (int k = 0; k < 20; k++) push({1'h1, 8'(k)});
        idle(4);
        check({2'h0, rx_int_out, rx_ready_out, level_out}, 9'h010);
        check(9'(n_ev + n_eint), 9'h001);
        rst_in = 1'h1;
        @(negedge core_clk_in);
        check({pop_valid_out, err_cond_out, 2'h0, level_out}, 9'h000);
        @(negedge core_clk_in);
        rst_in = 1'h0;
        check({8'h00, rx_ready_out}, 9'h000);
        @(negedge core_clk_in);
        check({3'h0, rx_ready_out, level_out}, 9'h020);
        wrap_up();
    end
endmodule // uart_rx_fifo_dma_event_gating_test
